/* File: fab_bank.sv */
// register bank top: request decode, field instances and registered answer
// Functional notes
// - reserved static fields read their reset value; writes change nothing
// - read-only fields return current value; writes are ignored
// - write-only fields take written value; read value is undefined
// - read/write fields store writes and read back current value
// - read-to-clear field returns value, then becomes 0; writes ignored
// - read-sets field returns value, then becomes 1; writes ignored
// - writing 0 forces write-zero-only field to 0; writing 1 does nothing
// - writing 1 forces write-one-only field to 1; writing 0 does nothing
// - writing 1 clears a write-one-to-clear field; writing 0 does nothing
// - writing 0 sets a write-zero-to-set field; writing 1 does nothing
// - registers decode at peripheral base plus register offset
// - registers are 32 bits wide
// - bits numbered little-endian, least significant bit is bit 0
// - byte-addressed space; 32-bit access, 8 and 16 bit via byte enables
// - registers only placed within 0x0000_0000 to 0x5FFF_FFFF
`timescale 1ns/1ps
`default_nettype none

module fab_bank #(
    parameter logic [31:0] BASE = fab_pkg::FAB_BASE_DFLT
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire fab_pkg::fab_req_t req_i,
    input wire logic [7:0] stat_val_i,
    input wire logic rc_set_i,
    input wire logic rdset_clr_i,
    input wire logic w1c_set_i,
    input wire logic wzs_clr_i,
    output fab_pkg::fab_rsp_t rsp_o,
    output logic [15:0] ctrl_o,
    output logic [31:0] wdat_o,
    output logic [3:0] flag_o,
    output logic [3:0] preserve_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte lane enables widened to a bit mask, lane 0 is bits 7:0
    function automatic logic [31:0] fab_lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic hit_w;
    logic [1:0] idx_w;

    fab_decode #(
        .BASE(BASE)
    ) u_decode (
        .addr_i(req_i.addr),
        .be_i(req_i.be),
        .hit_o(hit_w),
        .idx_o(idx_w)
    );

    wire [31:0] wdata_w = req_i.wdata;
    wire [31:0] mask_w = fab_lane_mask(req_i.be);
    wire go_w = req_i.valid && hit_w;
    wire wr_w = go_w && req_i.write;
    wire rd_w = go_w && !req_i.write;
    wire sel_ctrl_w = (idx_w == fab_pkg::FAB_OFS_CTRL[3:2]);
    wire sel_stat_w = (idx_w == fab_pkg::FAB_OFS_STAT[3:2]);
    wire sel_flag_w = (idx_w == fab_pkg::FAB_OFS_FLAG[3:2]);
    wire sel_wdat_w = (idx_w == fab_pkg::FAB_OFS_WDAT[3:2]);
    wire wr_ctrl_w = wr_w && sel_ctrl_w;
    wire rd_stat_w = rd_w && sel_stat_w;
    wire wr_stat_w = wr_w && sel_stat_w;
    wire wr_flag_w = wr_w && sel_flag_w;
    wire wr_wdat_w = wr_w && sel_wdat_w;

    ////////////////////////////////////////////////////////////////////////
    // control register

    logic [15:0] ctrl_rd_w;

    fab_field #(.W(16), .ACC(fab_pkg::FAB_ACC_RW), .RST(fab_pkg::FAB_CTRL_RW_RST)) u_ctrl_rw (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_ctrl_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_CTRL_RW_LSB +: 16]),
        .wdata_i(wdata_w[fab_pkg::FAB_CTRL_RW_LSB +: 16]),
        .hw_i(16'h0000),
        .q_o(ctrl_o),
        .rdata_o(ctrl_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // status register

    logic [7:0] ro_q_w;
    logic [7:0] ro_rd_w;
    logic [0:0] rc_q_w;
    logic [0:0] rc_rd_w;
    logic [0:0] read_sets_field;
    logic [0:0] rdset_rd_w;

    // write strobe reaches the field but the read-only behaviour discards it
    fab_field #(.W(8), .ACC(fab_pkg::FAB_ACC_RO), .RST(fab_pkg::FAB_STAT_RO_RST)) u_stat_ro (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_stat_w),
        .rd_i(rd_stat_w),
        .mask_i(mask_w[fab_pkg::FAB_STAT_RO_LSB +: 8]),
        .wdata_i(wdata_w[fab_pkg::FAB_STAT_RO_LSB +: 8]),
        .hw_i(stat_val_i),
        .q_o(ro_q_w),
        .rdata_o(ro_rd_w)
    );

    fab_field #(.W(1), .ACC(fab_pkg::FAB_ACC_RDCLR), .RST(fab_pkg::FAB_STAT_RC_RST)) u_stat_rc (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_stat_w),
        .rd_i(rd_stat_w),
        .mask_i(mask_w[fab_pkg::FAB_STAT_RC_LSB +: 1]),
        .wdata_i(wdata_w[fab_pkg::FAB_STAT_RC_LSB +: 1]),
        .hw_i(rc_set_i),
        .q_o(rc_q_w),
        .rdata_o(rc_rd_w)
    );

    fab_field #(.W(1), .ACC(fab_pkg::FAB_ACC_RDSET), .RST(fab_pkg::FAB_STAT_RDSET_RST)) u_stat_rdset (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_stat_w),
        .rd_i(rd_stat_w),
        .mask_i(mask_w[fab_pkg::FAB_STAT_RDSET_LSB +: 1]),
        .wdata_i(wdata_w[fab_pkg::FAB_STAT_RDSET_LSB +: 1]),
        .hw_i(rdset_clr_i),
        .q_o(read_sets_field),
        .rdata_o(rdset_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // flag register

    logic [3:0] flag_rd_w;
    logic [3:0] keep_rd_w;
    logic [7:0] fix_q_w;
    logic [7:0] fix_rd_w;

    // one generic cell per flag bit, each with its own write behaviour
    fab_field #(.W(1), .ACC(fab_pkg::FAB_ACC_WZERO), .RST(fab_pkg::FAB_FLAG_WZ_RST)) u_write_zero_only_field (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_flag_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_FLAG_WZ_LSB]),
        .wdata_i(wdata_w[fab_pkg::FAB_FLAG_WZ_LSB]),
        .hw_i(1'b0),
        .q_o(flag_o[0]),
        .rdata_o(flag_rd_w[0])
    );

    fab_field #(.W(1), .ACC(fab_pkg::FAB_ACC_WONE), .RST(fab_pkg::FAB_FLAG_WO_RST)) u_write_one_only_field (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_flag_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_FLAG_WO_LSB]),
        .wdata_i(wdata_w[fab_pkg::FAB_FLAG_WO_LSB]),
        .hw_i(1'b0),
        .q_o(flag_o[1]),
        .rdata_o(flag_rd_w[1])
    );

    fab_field #(.W(1), .ACC(fab_pkg::FAB_ACC_W1C), .RST(fab_pkg::FAB_FLAG_W1C_RST)) u_w1c_field (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_flag_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_FLAG_W1C_LSB]),
        .wdata_i(wdata_w[fab_pkg::FAB_FLAG_W1C_LSB]),
        .hw_i(w1c_set_i),
        .q_o(flag_o[2]),
        .rdata_o(flag_rd_w[2])
    );

    fab_field #(.W(1), .ACC(fab_pkg::FAB_ACC_WZSET), .RST(fab_pkg::FAB_FLAG_WZS_RST)) u_write_zero_to_set_field (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_flag_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_FLAG_WZS_LSB]),
        .wdata_i(wdata_w[fab_pkg::FAB_FLAG_WZS_LSB]),
        .hw_i(wzs_clr_i),
        .q_o(flag_o[3]),
        .rdata_o(flag_rd_w[3])
    );

    // stored as written; software is trusted to write back what it read
    fab_field #(.W(4), .ACC(fab_pkg::FAB_ACC_KEEP), .RST(fab_pkg::FAB_FLAG_KEEP_RST)) u_preserve_on_write_field (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_flag_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_FLAG_KEEP_LSB +: 4]),
        .wdata_i(wdata_w[fab_pkg::FAB_FLAG_KEEP_LSB +: 4]),
        .hw_i(4'h0),
        .q_o(preserve_o),
        .rdata_o(keep_rd_w)
    );

    fab_field #(.W(8), .ACC(fab_pkg::FAB_ACC_RSVD), .RST(fab_pkg::FAB_FLAG_FIX_RST)) u_flag_fix (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_flag_w),
        .rd_i(1'b0),
        .mask_i(mask_w[fab_pkg::FAB_FLAG_FIX_LSB +: 8]),
        .wdata_i(wdata_w[fab_pkg::FAB_FLAG_FIX_LSB +: 8]),
        .hw_i(8'h00),
        .q_o(fix_q_w),
        .rdata_o(fix_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // write-only data register

    logic [31:0] wdat_rd_w;

    fab_field #(.W(32), .ACC(fab_pkg::FAB_ACC_WO), .RST(fab_pkg::FAB_WDAT_RST)) u_wdat_wo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(wr_wdat_w),
        .rd_i(1'b0),
        .mask_i(mask_w),
        .wdata_i(wdata_w),
        .hw_i(32'h0000_0000),
        .q_o(wdat_o),
        .rdata_o(wdat_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path and answer

    // unused upper bits are reserved and read as zero
    wire [31:0] ctrl_word_w = {16'h0000, ctrl_rd_w};
    wire [31:0] stat_word_w = {22'h00_0000, rdset_rd_w, rc_rd_w, ro_rd_w};
    wire [31:0] flag_word_w = {16'h0000, fix_rd_w, keep_rd_w, flag_rd_w};
    wire [31:0] word_w = sel_ctrl_w ? ctrl_word_w :
                         sel_stat_w ? stat_word_w :
                         sel_flag_w ? flag_word_w : wdat_rd_w;
    wire [31:0] rdata_nxt = rd_w ? (word_w & mask_w) : 32'h0000_0000;

    fab_pkg::fab_rsp_t rsp_r;

    // answer one cycle after the request; misses answer with an error
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r.ack <= req_i.valid;
            rsp_r.err <= req_i.valid && !hit_w;
            rsp_r.rdata <= rdata_nxt;
        end
    end

    assign rsp_o = rsp_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_ack_next_cycle: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        req_i.valid |=> rsp_o.ack && ($past(hit_w) == !rsp_o.err))
        else $error("answer missing or error flag wrong");

    a_miss_out_space: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        req_i.valid && req_i.addr > fab_pkg::FAB_SPACE_TOP |=> rsp_o.err)
        else $error("access above mapped space not refused");

    a_fix_stays_reset: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        fix_q_w == fab_pkg::FAB_FLAG_FIX_RST)
        else $error("static field left its reset value");

    a_ro_follows_input: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_stat_w ##1 1'b1 |-> ro_q_w == $past(stat_val_i))
        else $error("read-only field changed by a write");

    a_rw_stores_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_ctrl_w && req_i.be == 4'hF |=> ctrl_o == $past(wdata_w[15:0]))
        else $error("read/write field did not store the write");

    a_ctrl_upper_zero: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rd_w && sel_ctrl_w |=> rsp_o.rdata[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");

    a_rc_clear_read: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rd_stat_w && req_i.be[1] && !rc_set_i |=> rc_q_w == 1'b0 && rsp_o.rdata[8] == $past(rc_q_w))
        else $error("read-to-clear field not cleared after read");

    a_rdset_on_read: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rd_stat_w && req_i.be[1] |=> read_sets_field == 1'b1)
        else $error("read-sets field not set after read");

    a_wzero_no_rise: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !$rose(flag_o[0]))
        else $error("write-zero-only field rose");

    a_wone_no_fall: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !$fell(flag_o[1]))
        else $error("write-one-only field fell");

    a_w1c_clears: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_flag_w && req_i.be[0] && wdata_w[2] && !w1c_set_i |=> !flag_o[2])
        else $error("write one did not clear the field");

    a_wzs_sets: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_flag_w && req_i.be[0] && !wdata_w[3] |=> flag_o[3])
        else $error("write zero did not set the field");

endmodule

`default_nettype wire

/* File: fab_pkg.sv */
// package: constants, access types and carriers for the field access register bank
package fab_pkg;

    typedef enum logic [3:0] {
        FAB_ACC_RSVD,
        FAB_ACC_KEEP,
        FAB_ACC_RO,
        FAB_ACC_WO,
        FAB_ACC_RW,
        FAB_ACC_RDCLR,
        FAB_ACC_RDSET,
        FAB_ACC_WZERO,
        FAB_ACC_WONE,
        FAB_ACC_W1C,
        FAB_ACC_WZSET
    } fab_access_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } fab_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } fab_rsp_t;

    ////////////////////////////////////////////////////////////////////////
    // address map
    localparam logic [31:0] FAB_BASE_DFLT = 32'h4000_1000;
    localparam logic [31:0] FAB_SPACE_TOP = 32'h5FFF_FFFF;
    localparam logic [31:0] FAB_SPAN_MASK = 32'h0000_000F;
    localparam logic [31:0] FAB_OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] FAB_OFS_STAT = 32'h0000_0004;
    localparam logic [31:0] FAB_OFS_FLAG = 32'h0000_0008;
    localparam logic [31:0] FAB_OFS_WDAT = 32'h0000_000C;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int FAB_CTRL_RW_LSB = 0;
    localparam int FAB_STAT_RO_LSB = 0;
    localparam int FAB_STAT_RC_LSB = 8;
    localparam int FAB_STAT_RDSET_LSB = 9;
    localparam int FAB_FLAG_WZ_LSB = 0;
    localparam int FAB_FLAG_WO_LSB = 1;
    localparam int FAB_FLAG_W1C_LSB = 2;
    localparam int FAB_FLAG_WZS_LSB = 3;
    localparam int FAB_FLAG_KEEP_LSB = 4;
    localparam int FAB_FLAG_FIX_LSB = 8;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] FAB_CTRL_RW_RST = 16'h0000;
    localparam logic [7:0] FAB_STAT_RO_RST = 8'h00;
    localparam logic [0:0] FAB_STAT_RC_RST = 1'h0;
    localparam logic [0:0] FAB_STAT_RDSET_RST = 1'h0;
    localparam logic [0:0] FAB_FLAG_WZ_RST = 1'h1;
    localparam logic [0:0] FAB_FLAG_WO_RST = 1'h0;
    localparam logic [0:0] FAB_FLAG_W1C_RST = 1'h0;
    localparam logic [0:0] FAB_FLAG_WZS_RST = 1'h1;
    localparam logic [3:0] FAB_FLAG_KEEP_RST = 4'h5;
    localparam logic [7:0] FAB_FLAG_FIX_RST = 8'h3C;
    localparam logic [31:0] FAB_WDAT_RST = 32'h0000_0000;

endpackage

/* File: fab_decode.sv */
// address decoder: bank hit and register index for one request
`timescale 1ns/1ps
`default_nettype none

module fab_decode #(
    parameter logic [31:0] BASE = fab_pkg::FAB_BASE_DFLT
) (
    input wire logic [31:0] addr_i,
    input wire logic [3:0] be_i,
    output logic hit_o,
    output logic [1:0] idx_o
);

    // the bank may only live inside the mapped space
    wire in_space_w = (addr_i <= fab_pkg::FAB_SPACE_TOP);
    wire in_bank_w = ((addr_i & ~fab_pkg::FAB_SPAN_MASK) == BASE);
    // narrow accesses use byte enables on an aligned word address
    wire aligned_w = (addr_i[1:0] == 2'h0) && (be_i != 4'h0);

    assign hit_o = in_space_w && in_bank_w && aligned_w;
    assign idx_o = addr_i[3:2];

endmodule

`default_nettype wire

/* File: fab_field.sv */
// one register field with a selectable access behaviour
`timescale 1ns/1ps
`default_nettype none

module fab_field #(
    parameter int W = 1,
    parameter fab_pkg::fab_access_t ACC = fab_pkg::FAB_ACC_RW,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [W-1:0] mask_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [W-1:0] hw_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] rdata_o
);

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    wire [W-1:0] wm_w = wr_i ? mask_i : '0;
    wire [W-1:0] rm_w = rd_i ? mask_i : '0;
    wire [W-1:0] wone_w = wm_w & wdata_i;
    wire [W-1:0] wzero_w = wm_w & ~wdata_i;

    // hardware events win over software clears in the same cycle
    always_comb begin
        unique case (ACC)
            fab_pkg::FAB_ACC_RSVD: q_nxt = RST;
            fab_pkg::FAB_ACC_RO: q_nxt = hw_i;
            fab_pkg::FAB_ACC_KEEP,
            fab_pkg::FAB_ACC_WO,
            fab_pkg::FAB_ACC_RW: q_nxt = (q_r & ~wm_w) | (wdata_i & wm_w);
            fab_pkg::FAB_ACC_RDCLR: q_nxt = (q_r & ~rm_w) | hw_i;
            fab_pkg::FAB_ACC_RDSET: q_nxt = (q_r & ~hw_i) | rm_w;
            fab_pkg::FAB_ACC_WZERO: q_nxt = q_r & ~wzero_w;
            fab_pkg::FAB_ACC_WONE: q_nxt = q_r | wone_w;
            fab_pkg::FAB_ACC_W1C: q_nxt = (q_r & ~wone_w) | hw_i;
            fab_pkg::FAB_ACC_WZSET: q_nxt = (q_r & ~hw_i) | wzero_w;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
    // write-only content is not returned; reads give zero
    assign rdata_o = (ACC == fab_pkg::FAB_ACC_WO) ? '0 : q_r;

endmodule

`default_nettype wire

/* File: fab_bank_tb.sv */
// self-checking testbench for the field access register bank
`timescale 1ns/1ps
`default_nettype none

module fab_bank_tb;
    localparam logic [31:0] B = fab_pkg::FAB_BASE_DFLT;

    logic clk_i;
    logic nrst_i;
    fab_pkg::fab_req_t req;
    fab_pkg::fab_rsp_t rsp;
    fab_pkg::fab_rsp_t got;
    logic [7:0] stat_val;
    logic [3:0] hw;
    logic [15:0] ctrl;
    logic [31:0] wdat;
    logic [3:0] flag;
    logic [3:0] preserve;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    fab_bank #(.BASE(B)) i_fab_bank (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .req_i(req),
        .stat_val_i(stat_val),
        .rc_set_i(hw[3]),
        .rdset_clr_i(hw[2]),
        .w1c_set_i(hw[1]),
        .wzs_clr_i(hw[0]),
        .rsp_o(rsp),
        .ctrl_o(ctrl),
        .wdat_o(wdat),
        .flag_o(flag),
        .preserve_o(preserve)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // the whole run needs under a hundred cycles; 3000 leaves ample margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            $display("Error timeout expected finish seen hang");
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one request driven at a falling edge, taken at the next rising edge;
    // the answer stands for one cycle only, so it is caught at the next falling edge
    task automatic acc(input logic wr, input logic [31:0] addr, input logic [31:0] wd, input logic [3:0] be);
        @(negedge clk_i);
        req.valid = 1'b1;
        req.write = wr;
        req.addr = addr;
        req.wdata = wd;
        req.be = be;
        @(negedge clk_i);
        got = rsp;
        req.valid = 1'b0;
        chk("ack", {31'h0, got.ack}, 32'h1);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [3:0] be, input logic [31:0] exp, input string what);
        acc(1'b0, addr, 32'h0, be);
        chk(what, got.rdata, exp);
    endtask

    // order of bits: read-clear set, read-sets clear, w1c set, wzs clear
    task automatic hw_pulse(input logic [3:0] v);
        @(negedge clk_i);
        hw = v;
        @(negedge clk_i);
        hw = 4'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("ctrl_o", {16'h0, ctrl}, 32'h0);
        chk("wdat_o", wdat, 32'h0);
        chk("flag_o", {28'h0, flag}, 32'h9);
        chk("preserve_o", {28'h0, preserve}, 32'h5);
        rd(B, 4'hF, 32'h0, "ctrl rd");
        rd(B + 32'h8, 4'hF, 32'h0000_3C59, "flag rd");
        $display("test reset done");
    endtask

    task automatic t_rw();
        acc(1'b1, B, 32'hFFFF_A5C3, 4'hF);
        chk("ctrl_o", {16'h0, ctrl}, 32'hA5C3);
        rd(B, 4'hF, 32'h0000_A5C3, "ctrl rd");
        acc(1'b1, B, 32'h0000_77FF, 4'h2);
        chk("ctrl_o lane", {16'h0, ctrl}, 32'h77C3);
        rd(B, 4'h1, 32'h0000_00C3, "ctrl byte");
        $display("test rw done");
    endtask

    task automatic t_stat();
        hw_pulse(4'h4);
        stat_val = 8'h3C;
        acc(1'b1, B + 32'h4, 32'hFFFF_FFFF, 4'hF);
        rd(B + 32'h4, 4'h1, 32'h0000_003C, "stat byte");
        // lane 1 not read above, so bit 9 must still be clear here
        rd(B + 32'h4, 4'hF, 32'h0000_003C, "stat rd");
        rd(B + 32'h4, 4'hF, 32'h0000_023C, "stat set");
        hw_pulse(4'h8);
        rd(B + 32'h4, 4'hF, 32'h0000_033C, "stat rc");
        rd(B + 32'h4, 4'hF, 32'h0000_023C, "stat clr");
        acc(1'b1, B + 32'h4, 32'h0000_0100, 4'hF);
        rd(B + 32'h4, 4'hF, 32'h0000_023C, "stat wr");
        hw_pulse(4'h4);
        stat_val = 8'hC1;
        @(negedge clk_i);
        // full word: bit 9 must show the hardware clear
        rd(B + 32'h4, 4'hF, 32'h0000_00C1, "stat live");
        $display("test stat done");
    endtask

    task automatic t_wo();
        acc(1'b1, B + 32'hC, 32'hDEAD_BEEF, 4'hF);
        chk("wdat_o", wdat, 32'hDEAD_BEEF);
        acc(1'b1, B + 32'hC, 32'h00AB_0000, 4'h4);
        chk("wdat_o lane", wdat, 32'hDEAB_BEEF);
        $display("test wo done");
    endtask

    task automatic t_flag();
        logic [31:0] keep;
        hw_pulse(4'h3);
        chk("flag_o hw", {28'h0, flag}, 32'h5);
        rd(B + 32'h8, 4'hF, 32'h0000_3C55, "flag rd");
        // software keeps the preserved field by writing back what it read
        keep = got.rdata & 32'h0000_00F0;
        acc(1'b1, B + 32'h8, 32'hFFFF_FF0F | keep, 4'hF);
        chk("flag_o ones", {28'h0, flag}, 32'h3);
        chk("preserve_o", {28'h0, preserve}, 32'h5);
        rd(B + 32'h8, 4'hF, 32'h0000_3C53, "flag fix");
        acc(1'b1, B + 32'h8, keep, 4'hF);
        chk("flag_o zeros", {28'h0, flag}, 32'hA);
        chk("flag_o wzs", {31'h0, flag[3]}, 32'h1);
        acc(1'b1, B + 32'h8, 32'h0000_000A | keep, 4'hF);
        chk("flag_o keep", {28'h0, flag}, 32'hA);
        chk("preserve_o kept", {28'h0, preserve}, 32'h5);
        rd(B + 32'h8, 4'hF, 32'h0000_3C5A, "flag rd2");
        $display("test flag done");
    endtask

    task automatic t_miss();
        logic [31:0] bad [4];
        bad = '{B + 32'h10, B + 32'h1, B - 32'h4, 32'hE000_1000};
        foreach (bad[i]) begin
            acc(1'b1, bad[i], 32'hFFFF_FFFF, 4'hF);
            chk("miss err", {31'h0, got.err}, 32'h1);
            chk("miss ctrl", {16'h0, ctrl}, 32'h77C3);
        end
        acc(1'b1, B, 32'h0, 4'h0);
        chk("be0 err", {31'h0, got.err}, 32'h1);
        rd(B + 32'h10, 4'hF, 32'h0, "miss rd");
        chk("miss rd err", {31'h0, got.err}, 32'h1);
        rd(B, 4'hF, 32'h0000_77C3, "hit rd");
        chk("hit err", {31'h0, got.err}, 32'h0);
        $display("test miss done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        nrst_i = 1'b0;
        req = '0;
        stat_val = 8'h00;
        hw = 4'h0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_rw();
        t_stat();
        t_wo();
        t_flag();
        t_miss();
        stop_test();
    end
endmodule

`default_nettype wire
